// ### hdl/boot_loader_dev.sv
// Device end: boot loader command interpreter
`timescale 1ns/1ps
`default_nettype none
module boot_loader_dev
  import boot_proto_pkg::*;
#(
  parameter logic [255:0] BAUD_VALID = 256'h1 << BAUD_INIT,
  parameter logic [7:0]   CHIP_RANGE = 8'h1f
) (
  input  wire logic        clk,
  input  wire logic        sys_rst,
  input  wire logic        ce,
  boot_link_if.dev         link,
  output logic [15:0]      memAddr,
  input  wire logic [7:0]  memData,
  input  wire logic        blankArea,
  input  wire logic        readProt,
  output logic             wrValid,
  output logic [15:0]      wrAddr,
  output logic [7:0]       wrData,
  output logic             eraseReq,
  output logic [7:0]       eraseRange,
  output logic             sumReq,
  input  wire logic        jobDone,
  input  wire logic [15:0] jobSum,
  output logic             halted
);

  if (BAUD_VALID == 256'h0) begin : g_chk
    $error("BAUD_VALID accepts no code");
  end

  typedef struct packed {
    dev_st_e     st;
    dev_st_e     ret;
    logic [7:0]  txData;
    logic        txValid;
    logic [3:0]  txCnt;
    logic [7:0]  errCode;
    logic [7:0]  cmd;
    logic [1:0]  aIdx;
    logic [15:0] cntAddr;
    logic [15:0] cmpAddr;
    logic [15:0] memAddr;
    logic [7:0]  pwLeft;
    logic [7:0]  rxByte;
    logic [7:0]  baud;
    logic        baudPend;
    logic [7:0]  linkBaud;
    logic [7:0]  recLen;
    logic [2:0]  recPos;
    logic [7:0]  recSum;
    logic [7:0]  recType;
    logic [15:0] recAddr;
    logic [15:0] sum;
    logic        wrValid;
    logic        eraseReq;
    logic        jobReq;
    logic        halt;
  } dev_s;

  dev_s r;
  dev_s n;

  // ==========================================================
  // Next state
  always_comb begin
    n          = r;
    n.wrValid  = 1'b0;
    n.eraseReq = 1'b0;
    n.jobReq   = 1'b0;
    case (r.st)
      D_MATCH: begin
        if (link.hValid && !link.hErr && link.hData == MATCH_BYTE) begin
          n.txData  = MATCH_BYTE;
          n.txValid = 1'b1;
          n.ret     = D_BAUD;
          n.st      = D_TX;
        end
      end
      D_TX: begin
        if (link.dReady) begin
          n.txValid = 1'b0;
          n.st      = r.ret;
          if (r.baudPend) begin
            n.linkBaud = r.baud;
            n.baudPend = 1'b0;
          end
        end
      end
      D_BAUD: begin
        if (link.hValid) begin
          if (!link.hErr && BAUD_VALID[link.hData]) begin
            n.baud     = link.hData;
            n.baudPend = 1'b1;
            n.txData   = link.hData;
            n.txValid  = 1'b1;
            n.ret      = D_CMD;
            n.st       = D_TX;
          end else begin
            n.errCode = ERR_BAUD;
            n.txCnt   = 4'h0;
            n.st      = D_ERR;
          end
        end
      end
      D_CMD: begin
        if (link.hValid) begin
          n.cmd  = link.hData;
          n.aIdx = 2'h0;
          if (link.hErr) begin
            n.st = D_HALT;
          end else if (link.hData == CMD_WRITE && readProt) begin
            n.st = D_HALT;
          end else if (link.hData == CMD_WRITE ||
                       link.hData == CMD_ERASE) begin
            n.txData  = link.hData;
            n.txValid = 1'b1;
            n.ret     = D_ADDR;
            n.st      = D_TX;
          end else begin
            n.errCode = ERR_CMD;
            n.txCnt   = 4'h0;
            n.st      = D_ERR;
          end
        end
      end
      D_ADDR: begin
        if (link.hValid) begin
          if (link.hErr) begin
            n.st = D_HALT;
          end else begin
            {n.cntAddr, n.cmpAddr} = {r.cntAddr[7:0], r.cmpAddr,
                                      link.hData};
            n.aIdx = r.aIdx + 2'h1;
            if (r.aIdx == ADDR_LAST) begin
              n.memAddr = {r.cntAddr[7:0], r.cmpAddr[15:8]};
              if (blankArea) begin
                n.st = (r.cmd == CMD_ERASE) ? D_RANGE : D_MARK;
              end else begin
                n.st = D_CNTRD;
              end
            end
          end
        end
      end
      D_CNTRD: begin
        n.st = D_CNTGET;
      end
      D_CNTGET: begin
        if (memData == 8'h00) begin
          n.st = D_HALT;
        end else begin
          n.pwLeft  = memData;
          n.memAddr = r.cmpAddr;
          n.st      = D_PWD;
        end
      end
      D_PWD: begin
        if (link.hValid) begin
          n.rxByte = link.hData;
          n.st     = link.hErr ? D_HALT : D_PWCMP;
        end
      end
      D_PWCMP: begin
        if (memData != r.rxByte) begin
          n.st = D_HALT;
        end else begin
          n.pwLeft  = r.pwLeft - 8'h01;
          n.memAddr = r.memAddr + 16'h0001;
          if (r.pwLeft == 8'h01) begin
            n.st = (r.cmd == CMD_ERASE) ? D_RANGE : D_MARK;
          end else begin
            n.st = D_PWD;
          end
        end
      end
      D_RANGE: begin
        if (link.hValid) begin
          if (link.hErr || (readProt && link.hData != CHIP_RANGE)) begin
            n.st = D_HALT;
          end else begin
            n.rxByte   = link.hData;
            n.eraseReq = 1'b1;
            n.st       = D_JOB;
          end
        end
      end
      D_MARK: begin
        if (link.hValid && !link.hErr && link.hData == REC_MARK) begin
          n.recPos = 3'h0;
          n.recSum = 8'h00;
          n.st     = D_REC;
        end
      end
      D_REC: begin
        if (link.hValid) begin
          n.recSum = r.recSum + link.hData;
          if (link.hErr) begin
            n.st = D_HALT;
          end else begin
            case (r.recPos)
              3'h0: begin
                n.recLen = link.hData;
                n.recPos = 3'h1;
              end
              3'h1: begin
                n.recAddr[15:8] = link.hData;
                n.recPos        = 3'h2;
              end
              3'h2: begin
                n.recAddr[7:0] = link.hData;
                n.recPos       = 3'h3;
              end
              3'h3: begin
                n.recType = link.hData;
                n.recPos  = (r.recLen == 8'h00) ? 3'h5 : 3'h4;
              end
              3'h4: begin
                n.wrValid = 1'b1;
                n.memAddr = r.recAddr;
                n.rxByte  = link.hData;
                n.recAddr = r.recAddr + 16'h0001;
                n.recLen  = r.recLen - 8'h01;
                if (r.recLen == 8'h01) begin
                  n.recPos = 3'h5;
                end
              end
              default: begin
                if (n.recSum != 8'h00 ||
                    (r.recType != REC_DATA && r.recType != REC_END)) begin
                  n.st = D_HALT;
                end else if (r.recType == REC_END) begin
                  n.jobReq = 1'b1;
                  n.st     = D_JOB;
                end else begin
                  n.st = D_MARK;
                end
              end
            endcase
          end
        end
      end
      D_JOB: begin
        if (jobDone) begin
          n.sum     = jobSum;
          n.txData  = jobSum[15:8];
          n.txValid = 1'b1;
          n.ret     = D_SUMLO;
          n.st      = D_TX;
        end
      end
      D_SUMLO: begin
        n.txData  = r.sum[7:0];
        n.txValid = 1'b1;
        n.ret     = D_CMD;
        n.st      = D_TX;
      end
      D_ERR: begin
        if (r.txValid) begin
          if (link.dReady) begin
            n.txValid = 1'b0;
          end
        end else if (r.txCnt == ERR_TOTAL) begin
          n.st = D_HALT;
        end else begin
          n.txValid = 1'b1;
          n.txCnt   = r.txCnt + 4'h1;
          n.txData  = (r.txCnt < ERR_REPEAT) ? ERR_LEAD0 :
                      (r.txCnt < ERR_MID)    ? ERR_LEAD1 : r.errCode;
        end
      end
      default: begin
        n.st      = D_HALT;
        n.txValid = 1'b0;
      end
    endcase
    n.halt = (n.st == D_HALT);
  end

  // ==========================================================
  // State register
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      r          <= '0;
      r.linkBaud <= BAUD_INIT;
    end else if (ce) begin
      r <= n;
    end
  end

  assign link.dValid   = r.txValid;
  assign link.dData    = r.txData;
  assign link.linkBaud = r.linkBaud;
  assign memAddr       = r.memAddr;
  assign wrValid       = r.wrValid;
  assign wrAddr        = r.memAddr;
  assign wrData        = r.rxByte;
  assign eraseReq      = r.eraseReq;
  assign eraseRange    = r.rxByte;
  assign sumReq        = r.jobReq;
  assign halted        = r.halt;

endmodule : boot_loader_dev
`default_nettype wire

// ### hdl/boot_proto_pkg.sv
// Constants and state codes shared by both ends of the boot link
package boot_proto_pkg;
  localparam logic [7:0] MATCH_BYTE = 8'h5a;
  localparam logic [7:0] ERR_LEAD0  = 8'ha1;
  localparam logic [7:0] ERR_LEAD1  = 8'ha3;
  localparam logic [7:0] ERR_BAUD   = 8'h62;
  localparam logic [7:0] ERR_CMD    = 8'h63;
  localparam logic [7:0] CMD_WRITE  = 8'h30;
  localparam logic [7:0] CMD_ERASE  = 8'hf0;
  localparam logic [7:0] REC_MARK   = 8'h3a;
  localparam logic [7:0] BAUD_INIT  = 8'h28;
  localparam logic [7:0] REC_DATA   = 8'h00;
  localparam logic [7:0] REC_END    = 8'h01;
  localparam logic [3:0] ERR_REPEAT = 4'h3;
  localparam logic [3:0] ERR_MID    = 4'h6;
  localparam logic [3:0] ERR_TOTAL  = 4'h9;
  localparam logic [1:0] ADDR_LAST  = 2'h3;
  localparam logic [2:0] HOST_GAP   = 3'h4;
  localparam int CLK_PERIOD_PS = 5000;
  localparam int RETRY_TIME_US = 100;
  localparam int RETRY_CYC     = RETRY_TIME_US * 1000000 / CLK_PERIOD_PS;

  typedef enum logic [3:0] {
    D_MATCH = 4'b0000, D_TX    = 4'b0001, D_BAUD  = 4'b0010,
    D_CMD   = 4'b0011, D_ADDR  = 4'b0100, D_CNTRD = 4'b0101,
    D_CNTGET= 4'b0110, D_PWD   = 4'b0111, D_PWCMP = 4'b1000,
    D_RANGE = 4'b1001, D_MARK  = 4'b1010, D_REC   = 4'b1011,
    D_JOB   = 4'b1100, D_SUMLO = 4'b1101, D_ERR   = 4'b1110,
    D_HALT  = 4'b1111
  } dev_st_e;

  typedef enum logic [3:0] {
    C_IDLE  = 4'b0000, C_MATCH = 4'b0001, C_WMATCH = 4'b0010,
    C_BAUD  = 4'b0011, C_WBAUD = 4'b0100, C_CMD    = 4'b0101,
    C_WCMD  = 4'b0110, C_ADDR  = 4'b0111, C_PAY    = 4'b1000,
    C_WSUMH = 4'b1001, C_WSUML = 4'b1010
  } ctrl_st_e;
endpackage : boot_proto_pkg

// ### hdl/boot_link_if.sv
// Byte-level link between the boot loader and the programming controller
`timescale 1ns/1ps
`default_nettype none
interface boot_link_if;
  logic       hValid;
  logic [7:0] hData;
  logic       hErr;
  logic       dValid;
  logic [7:0] dData;
  logic       dReady;
  logic [7:0] linkBaud;
  modport dev  (input hValid, hData, hErr, dReady,
                output dValid, dData, linkBaud);
  modport ctrl (output hValid, hData, hErr, dReady,
                input dValid, dData, linkBaud);
endinterface : boot_link_if
`default_nettype wire

// ### hdl/boot_prog_ctrl.sv
// Controller end: drives an erase or write session over the boot link
`timescale 1ns/1ps
`default_nettype none
module boot_prog_ctrl
  import boot_proto_pkg::*;
#(
  parameter int TIMEOUT = RETRY_CYC
) (
  input  wire logic        clk,
  input  wire logic        sys_rst,
  input  wire logic        ce,
  boot_link_if.ctrl        link,
  input  wire logic        go,
  input  wire logic [7:0]  cmdIn,
  input  wire logic [7:0]  baudIn,
  input  wire logic [15:0] cntAddrIn,
  input  wire logic [15:0] cmpAddrIn,
  input  wire logic        usrValid,
  input  wire logic [7:0]  usrData,
  input  wire logic        usrErr,
  input  wire logic        usrLast,
  output logic             usrReady,
  output logic             busy,
  output logic             sumValid,
  output logic [15:0]      sumOut,
  output logic             fail,
  output logic             tgtRst
);

  if (TIMEOUT < 1 || TIMEOUT > 65535) begin : g_chk
    $error("TIMEOUT out of range");
  end

  localparam logic [15:0] TO_LAST = 16'(TIMEOUT - 1);

  typedef struct packed {
    ctrl_st_e    st;
    logic [7:0]  cmd;
    logic [7:0]  baud;
    logic [31:0] addr;
    logic [1:0]  aIdx;
    logic [15:0] timer;
    logic [2:0]  gap;
    logic        linked;
    logic        hValid;
    logic [7:0]  hData;
    logic        hErr;
    logic        usrReady;
    logic        sumValid;
    logic [15:0] sum;
    logic        fail;
    logic        busy;
  } ctrl_s;

  ctrl_s r;
  ctrl_s n;
  logic  gapOk;
  logic  toHit;

  assign gapOk = (r.gap == HOST_GAP);
  assign toHit = (r.timer == TO_LAST);

  // ==========================================================
  // Next state
  always_comb begin
    n          = r;
    n.hValid   = 1'b0;
    n.hErr     = 1'b0;
    n.sumValid = 1'b0;
    n.fail     = 1'b0;
    n.timer    = r.timer + 16'h0001;
    if (!gapOk) begin
      n.gap = r.gap + 3'h1;
    end
    case (r.st)
      C_IDLE: begin
        if (go) begin
          n.cmd  = cmdIn;
          n.baud = baudIn;
          n.addr = {cntAddrIn, cmpAddrIn};
          n.st   = r.linked ? C_CMD : C_MATCH;
        end
      end
      C_MATCH, C_BAUD, C_CMD: begin
        if (gapOk) begin
          n.hValid = 1'b1;
          n.hData  = (r.st == C_MATCH) ? MATCH_BYTE :
                     (r.st == C_BAUD)  ? r.baud : r.cmd;
          n.gap    = 3'h0;
          n.timer  = 16'h0000;
          n.st     = ctrl_st_e'(r.st + 4'h1);
        end
      end
      C_WMATCH: begin
        if (link.dValid && link.dData == MATCH_BYTE) begin
          n.st = C_BAUD;
        end else if (toHit) begin
          n.st = C_MATCH;
        end
      end
      C_WBAUD, C_WCMD: begin
        if (link.dValid) begin
          if (link.dData == ((r.st == C_WBAUD) ? r.baud : r.cmd)) begin
            n.linked = 1'b1;
            n.aIdx   = 2'h0;
            n.st     = (r.st == C_WBAUD) ? C_CMD : C_ADDR;
          end else begin
            n.fail = 1'b1;
          end
        end else if (toHit) begin
          n.fail = 1'b1;
        end
      end
      C_ADDR: begin
        if (gapOk) begin
          n.hValid = 1'b1;
          n.hData  = r.addr[31:24];
          n.addr   = {r.addr[23:0], 8'h00};
          n.gap    = 3'h0;
          n.aIdx   = r.aIdx + 2'h1;
          if (r.aIdx == ADDR_LAST) begin
            n.st = C_PAY;
          end
        end
      end
      C_PAY: begin
        n.usrReady = gapOk && !(usrValid && r.usrReady);
        if (usrValid && r.usrReady) begin
          n.hValid = 1'b1;
          n.hData  = usrData;
          n.hErr   = usrErr;
          n.gap    = 3'h0;
          n.timer  = 16'h0000;
          if (usrLast) begin
            n.usrReady = 1'b0;
            n.st       = C_WSUMH;
          end
        end
      end
      C_WSUMH, C_WSUML: begin
        if (link.dValid) begin
          n.timer = 16'h0000;
          if (r.st == C_WSUMH) begin
            n.sum[15:8] = link.dData;
            n.st        = C_WSUML;
          end else begin
            n.sum[7:0] = link.dData;
            n.sumValid = 1'b1;
            n.st       = C_IDLE;
          end
        end else if (toHit) begin
          n.fail = 1'b1;
        end
      end
      default: begin
        n.st = C_IDLE;
      end
    endcase
    if (n.fail) begin
      n.linked   = 1'b0;
      n.usrReady = 1'b0;
      n.st       = C_IDLE;
    end
    n.busy = (n.st != C_IDLE);
  end

  // ==========================================================
  // State register
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      r     <= '0;
      r.gap <= HOST_GAP;
    end else if (ce) begin
      r <= n;
    end
  end

  assign link.hValid = r.hValid;
  assign link.hData  = r.hData;
  assign link.hErr   = r.hErr;
  assign link.dReady = 1'b1;
  assign usrReady    = r.usrReady;
  assign busy        = r.busy;
  assign sumValid    = r.sumValid;
  assign sumOut      = r.sum;
  assign fail        = r.fail;
  assign tgtRst      = r.fail;

endmodule : boot_prog_ctrl
`default_nettype wire

// ### sim/boot_link_monitor.sv
// Protocol checker watching the boot link between both ends
`timescale 1ns/1ps
`default_nettype none
module boot_link_monitor
  import boot_proto_pkg::*;
(
  input wire logic       clk,
  input wire logic       sys_rst,
  input wire logic       hValid,
  input wire logic [7:0] hData,
  input wire logic       hErr,
  input wire logic       dValid,
  input wire logic [7:0] dData,
  input wire logic       dReady,
  input wire logic [7:0] linkBaud
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);
  // ==========================================================
  // Helper state
  logic       take;
  logic [3:0] nTx_r;
  logic [1:0] errCnt_r;
  logic       errOn_r;
  assign take = dValid && dReady;
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      nTx_r    <= 4'h0;
      errCnt_r <= 2'h0;
      errOn_r  <= 1'b0;
    end else if (take) begin
      if (nTx_r != 4'hf)
        nTx_r <= nTx_r + 4'h1;
      if (dData == ERR_LEAD0 && nTx_r < 4'h3)
        errOn_r <= 1'b1;
      if (errOn_r && (dData == ERR_BAUD || dData == ERR_CMD))
        errCnt_r <= errCnt_r + 2'h1;
    end
  end
  // ==========================================================
  // Assertions
  property p_match_echo;
    hValid && !hErr && hData == MATCH_BYTE && nTx_r == 4'h0 && !dValid
      |=> dValid && dData == MATCH_BYTE;
  endproperty
  a_match_echo: assert property (p_match_echo)
    else $error("match byte not echoed");
  property p_only_match;
    hValid && nTx_r == 4'h0 |-> hData == MATCH_BYTE;
  endproperty
  a_only_match: assert property (p_only_match)
    else $error("host sent other than match byte before echo");
  property p_baud_echo;
    $rose(dValid) && nTx_r == 4'h1 && dData != ERR_LEAD0
      |-> $past(hValid) && $past(hData) == dData;
  endproperty
  a_baud_echo: assert property (p_baud_echo)
    else $error("baud echo differs from baud byte");
  property p_cmd_echo;
    $rose(dValid) && nTx_r == 4'h2 && dData != ERR_LEAD0
      |-> $past(hValid) && $past(hData) == dData
          && (dData == CMD_WRITE || dData == CMD_ERASE);
  endproperty
  a_cmd_echo: assert property (p_cmd_echo)
    else $error("command echo wrong");
  property p_bad_cmd;
    hValid && !hErr && nTx_r == 4'h2 && !errOn_r
      && hData != CMD_WRITE && hData != CMD_ERASE
      |=> !dValid ##1 dValid && dData == ERR_LEAD0;
  endproperty
  a_bad_cmd: assert property (p_bad_cmd)
    else $error("unknown command not answered with error lead");
  property p_err_next;
    take && (dData == ERR_LEAD0 || dData == ERR_LEAD1)
      && (errOn_r || nTx_r < 4'h3) |=> !dValid ##1 dValid;
  endproperty
  a_err_next: assert property (p_err_next)
    else $error("error code sequence broken");
  property p_err_halt;
    errCnt_r == 2'h3 |-> !dValid;
  endproperty
  a_err_halt: assert property (p_err_halt)
    else $error("byte sent after final error code");
  property p_baud_switch;
    linkBaud != $past(linkBaud) |-> $past(take) && $past(nTx_r) == 4'h1;
  endproperty
  a_baud_switch: assert property (p_baud_switch)
    else $error("baud changed outside its echo");
  c_match: cover property (take && dData == MATCH_BYTE);
  c_err: cover property (errCnt_r == 2'h3);
  c_baud: cover property (linkBaud != BAUD_INIT);
endmodule : boot_link_monitor
`default_nettype wire

// ### sim/serial_boot_erase_write_protocol_bench.sv
// Bench joining controller and boot loader over one link
`timescale 1ns/1ps
`default_nettype none
module serial_boot_erase_write_protocol_bench
  import boot_proto_pkg::*;
;
  localparam logic [7:0]   BAUD_ALT  = 8'h18;
  localparam logic [7:0]   CHIP_R    = 8'h1f;
  localparam logic [255:0] BAUD_MASK = (256'h1 << BAUD_INIT)
                                       | (256'h1 << BAUD_ALT);
  logic clk = 1'b0, sys_rst = 1'b1, ce = 1'b1, go = 1'b0, usrValid = 1'b0;
  logic usrErr = 1'b0, usrLast = 1'b0, blankArea = 1'b1, readProt = 1'b0;
  logic jobDone = 1'b0;
  logic [7:0] cmdIn = 8'h0, baudIn = 8'h0, usrData = 8'h0;
  logic [15:0] cntAddrIn = 16'h0, cmpAddrIn = 16'h0, jobSum = 16'h0;
  logic        usrReady, busy, sumValid, fail, tgtRst, wrValid;
  logic        eraseReq, sumReq, halted;
  logic [7:0]  memData, wrData, eraseRange, b, c, bb, d0, d1, rc, rng;
  logic [15:0] sumOut, memAddr, wrAddr, gotSum, a;
  logic [7:0]  mem [256];
  logic [7:0]  pay[$], txQ[$], expQ[$], eraseQ[$];
  logic [23:0] wrQ[$];
  int          fail_count, check_count, cyc, nSum, nFail, errAt, jobCnt;

  boot_link_if lnk ();
  boot_loader_dev #(.BAUD_VALID(BAUD_MASK), .CHIP_RANGE(CHIP_R))
  i_boot_loader_dev (.clk(clk), .sys_rst(sys_rst), .ce(ce), .link(lnk),
    .memAddr(memAddr), .memData(memData), .blankArea(blankArea),
    .readProt(readProt), .wrValid(wrValid), .wrAddr(wrAddr),
    .wrData(wrData), .eraseReq(eraseReq), .eraseRange(eraseRange),
    .sumReq(sumReq), .jobDone(jobDone), .jobSum(jobSum), .halted(halted));
  boot_prog_ctrl #(.TIMEOUT(200)) i_boot_prog_ctrl (.clk(clk),
    .sys_rst(sys_rst), .ce(ce), .link(lnk), .go(go), .cmdIn(cmdIn),
    .baudIn(baudIn), .cntAddrIn(cntAddrIn), .cmpAddrIn(cmpAddrIn),
    .usrValid(usrValid), .usrData(usrData), .usrErr(usrErr),
    .usrLast(usrLast), .usrReady(usrReady), .busy(busy),
    .sumValid(sumValid), .sumOut(sumOut), .fail(fail), .tgtRst(tgtRst));
  boot_link_monitor i_boot_link_monitor (.clk(clk), .sys_rst(sys_rst),
    .hValid(lnk.hValid), .hData(lnk.hData), .hErr(lnk.hErr),
    .dValid(lnk.dValid), .dData(lnk.dData), .dReady(lnk.dReady),
    .linkBaud(lnk.linkBaud));

  // ==========================================================
  // Clock, flash model, job engine and link recorder
  initial begin
    forever #2.5 clk = ~clk;
  end
  assign memData = mem[memAddr[7:0]];
  always @(posedge clk) begin
    cyc++;
    if (lnk.dValid && lnk.dReady)
      txQ.push_back(lnk.dData);
    if (wrValid)
      wrQ.push_back({wrAddr, wrData});
    if (eraseReq)
      eraseQ.push_back(eraseRange);
    if (sumValid) begin
      gotSum = sumOut;
      nSum++;
    end
    if (fail && tgtRst)
      nFail++;
    jobDone <= (jobCnt == 1);
    if (sumReq || eraseReq)
      jobCnt = 4;
    else if (jobCnt > 0)
      jobCnt--;
    if (cyc == 20000) begin
      fail_count++;
      results();
    end
  end

  // ==========================================================
  // Tasks
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      fail_count++;
      $display("unexpected at %0t: got %h exp %h", $time, got, exp);
    end
  endtask : chk
  function automatic void errSeq(input logic [7:0] code);
    repeat (3) expQ.push_back(ERR_LEAD0);
    repeat (3) expQ.push_back(ERR_LEAD1);
    repeat (3) expQ.push_back(code);
  endfunction : errSeq
  task automatic cmpTx(input int n);
    chk(txQ.size(), expQ.size());
    foreach (expQ[i])
      chk(txQ[i], expQ[i]);
    txQ.delete();
    $display("test %0d done, checks %0d", n, check_count);
  endtask : cmpTx
  task automatic rstDut(input int n);
    sys_rst <= 1'b1;
    repeat (n) @(posedge clk);
    sys_rst <= 1'b0;
    wrQ.delete();
    eraseQ.delete();
  endtask : rstDut
  task automatic send(input logic [7:0] d, input logic l, input logic e);
    @(posedge clk);
    usrValid <= 1'b1;
    usrData <= d;
    usrLast <= l;
    usrErr <= e;
    do @(posedge clk); while (!usrReady && nFail == 0 && nSum == 0);
    usrValid <= 1'b0;
  endtask : send
  task automatic session(input logic [7:0] cm, input logic [7:0] bd);
    while (busy) @(posedge clk);
    @(posedge clk);
    cmdIn <= cm;
    baudIn <= bd;
    cntAddrIn <= 16'h0010;
    cmpAddrIn <= 16'h0020;
    nSum = 0;
    nFail = 0;
    go <= 1'b1;
    @(posedge clk);
    go <= 1'b0;
    foreach (pay[i])
      send(pay[i], i == pay.size() - 1, i == errAt);
    for (int k = 0; k < 3000 && nSum == 0 && nFail == 0; k++)
      @(posedge clk);
  endtask : session
  task automatic results();
    $display("checks %0d mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : results

  // ==========================================================
  // Main sequence
  initial begin
    void'($urandom(32'h394c0ab2));
    foreach (mem[i])
      mem[i] = 8'($urandom);
    mem[8'h10] = 8'h03;
    errAt = -1;
    rstDut(10);
    a = {8'h40, 8'($urandom)};
    d0 = 8'($urandom);
    d1 = 8'($urandom);
    rc = 8'h00 - (8'h02 + a[15:8] + a[7:0] + d0 + d1);
    jobSum <= 16'($urandom);
    pay = '{8'h55, REC_MARK, 8'h02, a[15:8], a[7:0], REC_DATA, d0, d1, rc,
            REC_MARK, 8'h00, 8'h00, 8'h00, REC_END, 8'hff};
    session(CMD_WRITE, BAUD_ALT);
    expQ = '{MATCH_BYTE, BAUD_ALT, CMD_WRITE, jobSum[15:8], jobSum[7:0]};
    cmpTx(1);
    chk(wrQ.size(), 2);
    chk(wrQ[0], {a, d0});
    chk(wrQ[1], {a + 16'h1, d1});
    chk(gotSum, jobSum);
    rng = 8'($urandom);
    jobSum <= 16'($urandom);
    pay = '{rng};
    session(CMD_ERASE, BAUD_ALT);
    expQ = '{CMD_ERASE, jobSum[15:8], jobSum[7:0]};
    cmpTx(2);
    chk(eraseQ[0], rng);
    rstDut(2);
    blankArea <= 1'b0;
    readProt <= 1'b1;
    jobSum <= 16'($urandom);
    b = $urandom_range(1) ? BAUD_INIT : BAUD_ALT;
    pay = '{mem[8'h20], mem[8'h21], mem[8'h22], CHIP_R};
    session(CMD_ERASE, b);
    expQ = '{MATCH_BYTE, b, CMD_ERASE, jobSum[15:8], jobSum[7:0]};
    cmpTx(3);
    chk(eraseQ.size(), 1);
    for (int t = 0; t < 6; t++) begin
      rstDut(2);
      readProt <= (t == 2 || t == 5);
      pay = '{mem[8'h20], mem[8'h21], mem[8'h22], t == 5 ? 8'h12 : CHIP_R};
      if (t == 3)
        pay[1] = ~pay[1];
      errAt = (t == 4) ? 2 : -1;
      do bb = 8'($urandom);
      while (bb == BAUD_INIT || bb == BAUD_ALT || bb == ERR_LEAD0);
      do c = 8'($urandom);
      while (c == CMD_WRITE || c == CMD_ERASE || c == ERR_LEAD0);
      if (t != 0)
        bb = b;
      if (t == 2)
        c = CMD_WRITE;
      else if (t != 1)
        c = CMD_ERASE;
      session(c, bb);
      repeat (60) @(posedge clk);
      expQ = '{MATCH_BYTE};
      if (t == 0)
        errSeq(ERR_BAUD);
      else
        expQ.push_back(bb);
      if (t == 1)
        errSeq(ERR_CMD);
      else if (t > 2)
        expQ.push_back(c);
      cmpTx(t + 4);
      chk(nFail, 1);
      chk(eraseQ.size() + wrQ.size(), 0);
      if (t < 5)
        chk(halted, 1);
    end
    results();
  end
endmodule : serial_boot_erase_write_protocol_bench
`default_nettype wire
